// >>> hw/uart_rx_cmd_buffers_cts_consts.vh
// constants for the uart receiver command, buffers and clear-to-send block
`ifndef UART_RX_CMD_BUFFERS_CTS_CONSTS_VH
`define UART_RX_CMD_BUFFERS_CTS_CONSTS_VH
// register offsets on the 4-bit register port
`define OFS_CHANNEL_COMMAND   4'h0
`define OFS_RECEIVE_BUFFER    4'h1
`define OFS_TRANSMIT_BUFFER   4'h2
`define OFS_INPUT_PORT_CHANGE 4'h3
`define OFS_CHANNEL_CONFIG    4'h4
`define OFS_CHANNEL_STATUS    4'h5
`define OFS_INT_STATUS        4'h6
`define OFS_INT_MASK          4'h7
// receiver command codes in bits 1..0 of channel_command
`define RCMD_NONE    2'h0
`define RCMD_ENABLE  2'h1
`define RCMD_DISABLE 2'h2
`define RCMD_RSVD    2'h3
// parity mode code that selects multidrop
`define PM_MULTIDROP 2'h3
// field positions of channel_config
`define CFG_PM_LO    0
`define CFG_PM_HI    1
`define CFG_LOOPBACK 2
`define CFG_TX_EN    3
`define CFG_IEC      4
// field positions of input_port_change
`define IPC_CTS 0
`define IPC_COS 4
// field positions of interrupt status and mask
`define INT_COS     0
`define INT_RXRDY   1
`define INT_OVERRUN 2
// reset values
`define CONFIG_RESET 8'h00
`define MASK_RESET   3'h0
// clear-to-send filter: least persistence 25 us at 5 ns per cycle
`define CTS_FILTER_NS  25000
`define CLK_PERIOD_NS  5
`define CTS_FILTER_CYC ((`CTS_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// system clock periods from reset release until cts is tracked
`define CTS_START_CYC  2
// default bit time in system clocks
`define BIT_CYC_DEFAULT 16
`endif

// >>> hw/uart_rx_cmd_buffers_cts.v
// uart receiver command, receive fifo, transmit buffer and cts change logic
`include "uart_rx_cmd_buffers_cts_consts.vh"
`default_nettype none
// Operation
// - command bits 1..0 select receiver action
// - enable command starts start-bit hunt unless multidrop
// - disable command stops receiver, drops partial character
// - loop-back or multidrop keeps receiver running
// - one shift register feeding three-deep queue
// - cpu pops head, receiver pushes tail
// - accepted transmit write clears transmit ready
// - empty shifter loads holding register, sets ready
// - writes ignored when not ready or disabled
// - filtered cts edge sets change-of-state bit four
// - reading change register clears change indications
// - change interrupt only when input-change enabled
// - bit zero shows cts, zero when asserted
// - cts tracked two clocks after reset
module uart_rx_cmd_buffers_cts #(
  parameter integer BIT_CYC   = `BIT_CYC_DEFAULT, // system clocks per bit
  parameter integer CTS_CYC   = `CTS_FILTER_CYC,  // cts persistence count
  parameter integer FIFO_DEPTH = 3                // receive holding registers
) (
  input  wire       sys_clk_i,
  input  wire       srst_i,
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       receive_data_pin_i,
  input  wire       clear_to_send_input_n_i,
  output reg        transmit_data_pin_o,
  output reg        irq_o
);

  // pointer and count widths
  localparam integer PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam integer CW = $clog2(FIFO_DEPTH + 1);
  localparam integer BW = $clog2(BIT_CYC + 1);
  localparam integer FW = $clog2(CTS_CYC + 1);
  localparam [CW-1:0] FULL_CNT = FIFO_DEPTH[CW-1:0];
  localparam [BW-1:0] BIT_LAST = BIT_CYC[BW-1:0] - 1'b1;
  localparam [BW-1:0] BIT_HALF = BIT_CYC[BW-1:0] >> 1;
  localparam [FW-1:0] CTS_LAST = CTS_CYC[FW-1:0] - 1'b1;

  // serial state codes, shared by receiver and transmitter
  localparam [1:0] S_IDLE  = 2'h0;
  localparam [1:0] S_START = 2'h1;
  localparam [1:0] S_DATA  = 2'h2;
  localparam [1:0] S_STOP  = 2'h3;

  // decoded strobes
  function hit;
    input [3:0] a;
    input [3:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire wr_cmd = wr_i & hit(addr_i, `OFS_CHANNEL_COMMAND);
  wire wr_tb  = wr_i & hit(addr_i, `OFS_TRANSMIT_BUFFER);
  wire wr_cfg = wr_i & hit(addr_i, `OFS_CHANNEL_CONFIG);
  wire wr_is  = wr_i & hit(addr_i, `OFS_INT_STATUS);
  wire wr_im  = wr_i & hit(addr_i, `OFS_INT_MASK);
  wire rd_rb  = rd_i & hit(addr_i, `OFS_RECEIVE_BUFFER);
  wire rd_ipc = rd_i & hit(addr_i, `OFS_INPUT_PORT_CHANGE);

  // control registers
  reg  [7:0] cfg_q;          // mode, loop-back, tx enable, input-change enable
  reg  [2:0] int_mask_q;     // interrupt mask, same layout as status
  reg  [2:0] int_stat_q;     // sticky interrupt status
  reg        rx_en_q;        // receiver enabled by command
  wire [1:0] parity_mode_field = cfg_q[`CFG_PM_HI:`CFG_PM_LO];
  wire       multidrop = (parity_mode_field == `PM_MULTIDROP);
  wire       loopback  = cfg_q[`CFG_LOOPBACK];
  wire       tx_en     = cfg_q[`CFG_TX_EN];
  wire       iec       = cfg_q[`CFG_IEC];
  wire [1:0] receiver_command_field = wdata_i[1:0];

  // receiver runs when enabled or forced by loop-back / multidrop
  wire rx_active = rx_en_q | loopback | multidrop;

  // receiver enable bit driven by the command field
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_en_q <= 1'b0;
    end else if (wr_cmd) begin
      case (receiver_command_field)
        `RCMD_ENABLE: begin
          if (!multidrop) begin
            rx_en_q <= 1'b1;
          end
        end
        `RCMD_DISABLE: begin
          rx_en_q <= 1'b0;
        end
        default: begin
          rx_en_q <= rx_en_q; // no action, reserved code does nothing
        end
      endcase
    end
  end

  // configuration and mask registers
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      cfg_q      <= `CONFIG_RESET;
      int_mask_q <= `MASK_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_q <= wdata_i;
      end
      if (wr_im) begin
        int_mask_q <= wdata_i[2:0];
      end
    end
  end

  // ------------------------------------------------------------ transmit
  reg  [7:0] transmit_character_q; // holding register
  reg        transmit_ready_q;     // high when holding register is free
  reg        tx_busy_q;            // valid character waits in holding register
  reg  [7:0] tx_shift_q;
  reg  [1:0] tx_state_q;
  reg  [2:0] tx_bit_q;
  reg  [BW-1:0] tx_cnt_q;
  wire tx_tick = (tx_cnt_q == BIT_LAST);
  wire tx_take = wr_tb & transmit_ready_q & tx_en;
  wire tx_load = (tx_state_q == S_IDLE) & ~transmit_ready_q;

  // holding register and ready flag; a disabled transmitter has no ready
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      transmit_character_q <= 8'h00;
      transmit_ready_q     <= 1'b0;
    end else if (!tx_en) begin
      transmit_ready_q <= 1'b0;
    end else if (tx_take) begin
      transmit_character_q <= wdata_i;
      transmit_ready_q     <= 1'b0;
    end else if (tx_load && tx_state_q == S_IDLE && tx_busy_q) begin
      transmit_ready_q <= 1'b1;
    end else if (!tx_busy_q) begin
      transmit_ready_q <= 1'b1; // enable sets ready with holding register empty
    end
  end

  // tx_busy_q marks a valid character in the holding register
  always @(posedge sys_clk_i) begin
    if (srst_i || !tx_en) begin
      tx_busy_q <= 1'b0;
    end else if (tx_take) begin
      tx_busy_q <= 1'b1;
    end else if (tx_load && tx_busy_q) begin
      tx_busy_q <= 1'b0;
    end
  end

  // transmit shifter: start, eight data bits lsb first, one stop bit
  // a character in flight always finishes, even if tx is disabled
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_state_q          <= S_IDLE;
      tx_shift_q          <= 8'h00;
      tx_bit_q            <= 3'h0;
      tx_cnt_q            <= {BW{1'b0}};
      transmit_data_pin_o <= 1'b1;
    end else begin
      tx_cnt_q <= (tx_state_q == S_IDLE || tx_tick) ? {BW{1'b0}}
                                                    : tx_cnt_q + 1'b1;
      case (tx_state_q)
        S_IDLE: begin
          transmit_data_pin_o <= 1'b1;
          if (tx_load && tx_busy_q) begin
            tx_shift_q          <= transmit_character_q;
            tx_state_q          <= S_START;
            transmit_data_pin_o <= 1'b0;
          end
        end
        S_START: begin
          if (tx_tick) begin
            tx_state_q          <= S_DATA;
            tx_bit_q            <= 3'h0;
            transmit_data_pin_o <= tx_shift_q[0];
          end
        end
        S_DATA: begin
          if (tx_tick) begin
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q   <= tx_bit_q + 1'b1;
            if (tx_bit_q == 3'h7) begin
              tx_state_q          <= S_STOP;
              transmit_data_pin_o <= 1'b1;
            end else begin
              transmit_data_pin_o <= tx_shift_q[1];
            end
          end
        end
        S_STOP: begin
          if (tx_tick) begin
            tx_state_q <= S_IDLE;
          end
        end
        default: begin
          tx_state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------- receive
  // loop-back feeds the receiver from our own transmit line
  wire rx_line = loopback ? transmit_data_pin_o : receive_data_pin_i;
  reg  [1:0] rx_state_q;
  reg  [7:0] rx_shift_q;   // serial shift register
  reg  [2:0] rx_bit_q;
  reg  [BW-1:0] rx_cnt_q;
  reg        rx_push;      // complete character this cycle
  wire rx_tick = (rx_cnt_q == BIT_LAST);

  // receiver sequencer; sampling at mid bit after half-bit start check
  always @(posedge sys_clk_i) begin
    if (srst_i || !rx_active) begin
      rx_state_q <= S_IDLE;
      rx_shift_q <= 8'h00;
      rx_bit_q   <= 3'h0;
      rx_cnt_q   <= {BW{1'b0}};
      rx_push    <= 1'b0;
    end else begin
      rx_push  <= 1'b0;
      rx_cnt_q <= rx_tick ? {BW{1'b0}} : rx_cnt_q + 1'b1;
      case (rx_state_q)
        S_IDLE: begin
          rx_cnt_q <= {BW{1'b0}};
          if (!rx_line) begin
            rx_state_q <= S_START;
          end
        end
        S_START: begin
          // glitch shorter than half a bit returns to the hunt
          if (rx_cnt_q == BIT_HALF) begin
            rx_cnt_q <= {BW{1'b0}};
            if (rx_line) begin
              rx_state_q <= S_IDLE;
            end else begin
              rx_state_q <= S_DATA;
              rx_bit_q   <= 3'h0;
            end
          end
        end
        S_DATA: begin
          if (rx_tick) begin
            rx_shift_q <= {rx_line, rx_shift_q[7:1]};
            rx_bit_q   <= rx_bit_q + 1'b1;
            if (rx_bit_q == 3'h7) begin
              rx_state_q <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (rx_tick) begin
            rx_state_q <= S_IDLE;
            rx_push    <= 1'b1;
          end
        end
        default: begin
          rx_state_q <= S_IDLE;
        end
      endcase
    end
  end

  // receive queue of holding registers
  reg  [7:0]    rx_mem [0:FIFO_DEPTH-1];
  reg  [PW-1:0] rd_ptr_q;
  reg  [PW-1:0] wr_ptr_q;
  reg  [CW-1:0] rx_cnt_fifo_q;
  reg           overrun_q;
  wire fifo_full  = (rx_cnt_fifo_q == FULL_CNT);
  wire fifo_empty = (rx_cnt_fifo_q == {CW{1'b0}});
  wire do_push = rx_push & ~fifo_full;  // full queue drops the newcomer
  wire do_pop  = rd_rb & ~fifo_empty;

  // pointer wrap at the queue depth
  function [PW-1:0] nxt;
    input [PW-1:0] p;
    begin
      nxt = (p == FIFO_DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : p + 1'b1;
    end
  endfunction

  // queue pointers, count and overrun flag
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      rd_ptr_q      <= {PW{1'b0}};
      wr_ptr_q      <= {PW{1'b0}};
      rx_cnt_fifo_q <= {CW{1'b0}};
      overrun_q     <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= nxt(wr_ptr_q);
      end
      if (do_pop) begin
        rd_ptr_q <= nxt(rd_ptr_q);
      end
      if (do_push && !do_pop) begin
        rx_cnt_fifo_q <= rx_cnt_fifo_q + 1'b1;
      end else if (do_pop && !do_push) begin
        rx_cnt_fifo_q <= rx_cnt_fifo_q - 1'b1;
      end
      if (rx_push && fifo_full) begin
        overrun_q <= 1'b1;
      end
    end
  end

  // queue storage has no reset; unread slots are never shown
  always @(posedge sys_clk_i) begin
    if (do_push) begin
      rx_mem[wr_ptr_q] <= rx_shift_q;
    end
  end

  // ------------------------------------------------------- clear to send
  reg [1:0]    start_cnt_q;  // counts clocks after reset release
  reg          cts_live_q;   // tracking started
  reg          cts_state_q;  // filtered pin level, 1 = deasserted
  reg [FW-1:0] cts_cnt_q;    // persistence counter
  reg          cos_q;        // change-of-state, bit 4
  reg          cos_evt;      // one-cycle change event
  wire cts_pin = clear_to_send_input_n_i;

  // filter: a new level must hold for the whole count before it counts
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      start_cnt_q <= 2'h0;
      cts_live_q  <= 1'b0;
      cts_state_q <= 1'b1;
      cts_cnt_q   <= {FW{1'b0}};
      cos_evt     <= 1'b0;
    end else begin
      cos_evt <= 1'b0;
      if (!cts_live_q) begin
        start_cnt_q <= start_cnt_q + 1'b1;
        if (start_cnt_q == `CTS_START_CYC - 1) begin
          cts_live_q  <= 1'b1;
          cts_state_q <= cts_pin;
          cos_evt     <= ~cts_pin;
        end
      end else if (cts_pin == cts_state_q) begin
        cts_cnt_q <= {FW{1'b0}};
      end else if (cts_cnt_q == CTS_LAST) begin
        cts_cnt_q   <= {FW{1'b0}};
        cts_state_q <= cts_pin;
        cos_evt     <= 1'b1;
      end else begin
        cts_cnt_q <= cts_cnt_q + 1'b1;
      end
    end
  end

  // change-of-state flag: a new event beats a clearing read
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      cos_q <= 1'b0;
    end else if (cos_evt) begin
      cos_q <= 1'b1;
    end else if (rd_ipc) begin
      cos_q <= 1'b0;
    end
  end

  // ------------------------------------------------------ interrupt logic
  // sticky status, write one to clear; set wins over any clear
  wire [2:0] int_set = {rx_push & fifo_full, do_push, cos_evt & iec};
  wire [2:0] int_clr = (wr_is ? wdata_i[2:0] : 3'h0) |
                       {2'h0, rd_ipc};
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      int_stat_q <= 3'h0;
      irq_o      <= 1'b0;
    end else begin
      int_stat_q <= int_set | (int_stat_q & ~int_clr);
      irq_o      <= |(int_stat_q & int_mask_q);
    end
  end

  // ----------------------------------------------------------- read port
  wire [7:0] ipc_val = {3'h0, cos_q, 3'h0, cts_state_q};
  wire [7:0] status_val = {1'b0, overrun_q, rx_cnt_fifo_q[1:0],
                           tx_state_q != S_IDLE, tx_busy_q,
                           transmit_ready_q, rx_en_q};

  // read data stand one cycle after the strobe, zero otherwise
  always @(posedge sys_clk_i) begin
    if (srst_i || !rd_i) begin
      rdata_o <= 8'h00;
    end else begin
      case (addr_i)
        `OFS_RECEIVE_BUFFER:    rdata_o <= fifo_empty ? 8'h00
                                                      : rx_mem[rd_ptr_q];
        `OFS_INPUT_PORT_CHANGE: rdata_o <= ipc_val;
        `OFS_CHANNEL_CONFIG:    rdata_o <= cfg_q;
        `OFS_CHANNEL_STATUS:    rdata_o <= status_val;
        `OFS_INT_STATUS:        rdata_o <= {5'h00, int_stat_q};
        `OFS_INT_MASK:          rdata_o <= {5'h00, int_mask_q};
        default:                rdata_o <= 8'h00; // write-only or unmapped
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> verification/uart_rx_cmd_buffers_cts_sva.sv
// port assertions for the uart receiver command, buffers and cts block
`include "uart_rx_cmd_buffers_cts_consts.vh"
`default_nettype none
module uart_rx_cmd_buffers_cts_sva #(
  parameter integer CTS_CYC = 20  // cts persistence count of the dut
) (
  input wire logic       sys_clk_i,
  input wire logic       srst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       receive_data_pin_i,
  input wire logic       clear_to_send_input_n_i,
  input wire logic       transmit_data_pin_o,
  input wire logic       irq_o
);
  logic prev_q;  // cts pin one cycle ago
  int   cnt_q;   // cycles the pin has held, saturating
  logic lvl_q;   // last level that outlasted the filter
  logic chg_q;   // filtered change not read yet
  logic rdw_q;   // read close to the filter edge, outcome undecided
  wire  ipc_rd = rd_i && addr_i == `OFS_INPUT_PORT_CHANGE;
  wire  near   = cnt_q >= CTS_CYC - 4 && cnt_q <= CTS_CYC + 4;
  // reference filter: a margin of four cycles hides the exact latency
  always @(posedge sys_clk_i) begin
    prev_q <= clear_to_send_input_n_i;
    if (srst_i) begin
      cnt_q <= CTS_CYC + 5;
      lvl_q <= clear_to_send_input_n_i;
      chg_q <= 1'b0;
      rdw_q <= 1'b0;
    end else begin
      if (clear_to_send_input_n_i != prev_q) cnt_q <= 0;
      else if (cnt_q < CTS_CYC + 5) cnt_q <= cnt_q + 1;
      if (cnt_q == CTS_CYC + 4) lvl_q <= prev_q;
      if (ipc_rd) chg_q <= 1'b0;
      else if (cnt_q == CTS_CYC + 4 && prev_q != lvl_q && !rdw_q)
        chg_q <= 1'b1;
      if (cnt_q == 0) rdw_q <= 1'b0;
      else if (ipc_rd && near) rdw_q <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  a_ipc_rsvd_zero: assert property (
    ipc_rd |=> rdata_o[7:5] == 3'h0 && rdata_o[3:1] == 3'h0)
    else $error("reserved change bits not zero");
  a_cts_level: assert property (
    ipc_rd && !near |=> rdata_o[0] == $past(lvl_q))
    else $error("cts state bit wrong");
  a_cos_set: assert property (
    ipc_rd && chg_q |=> rdata_o[4])
    else $error("change of state missing");
  a_cos_read_clear: assert property (
    ipc_rd ##3 (ipc_rd && cnt_q > CTS_CYC + 4) |=> !rdata_o[4])
    else $error("change of state not cleared by read");
  a_cts_start: assert property (
    $fell(srst_i) ##3 (ipc_rd && cnt_q > CTS_CYC + 4) |=>
    rdata_o[0] == $past(clear_to_send_input_n_i) &&
    rdata_o[4] == !$past(clear_to_send_input_n_i))
    else $error("cts start tracking wrong");
  a_wo_read_zero: assert property (
    rd_i && (addr_i == `OFS_CHANNEL_COMMAND ||
    addr_i == `OFS_TRANSMIT_BUFFER) |=> rdata_o == 8'h00)
    else $error("write only register read not zero");
  a_rdata_idle: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_irq_masked: assert property (
    (wr_i && addr_i == `OFS_INT_MASK && wdata_i[2:0] == 3'h0) ##1
    !(wr_i && addr_i == `OFS_INT_MASK) |=> !irq_o)
    else $error("interrupt with all sources masked");
  c_cos_read: cover property (ipc_rd && chg_q);
  c_irq: cover property (irq_o);
  c_tx_write: cover property (wr_i && addr_i == `OFS_TRANSMIT_BUFFER);
endmodule
`default_nettype wire

// >>> verification/serial_peer.sv
// remote serial device on the receive, transmit and clear-to-send lines
`default_nettype none
module serial_peer #(
  parameter integer BIT_CYC = 8  // clocks per bit
) (
  input  wire logic clk_i,
  input  wire logic tx_pin_i,  // dut transmit line
  output var  logic rx_pin_o,  // dut receive line, idle high
  output var  logic cts_n_o    // clear to send, low when asserted
);
  logic [7:0] got [$];  // characters decoded from the transmit line
  initial begin
    rx_pin_o = 1'b1;
    cts_n_o  = 1'b0;
  end
  // whole 8n1 frame, lsb first, changed only after clock edges
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rx_pin_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask
  task automatic set_cts(input logic v);
    @(posedge clk_i);
    cts_n_o <= v;
  endtask
  // decoder samples mid bit; stop bit is not checked
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge tx_pin_i);
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk_i);
        b[i] = tx_pin_i;
      end
      // stop bit not waited: the loop rearms at its start, before a back-to-back frame
      repeat (BIT_CYC / 2) @(posedge clk_i);
      got.push_back(b);
    end
  end
endmodule
`default_nettype wire

// >>> verification/uart_rx_cmd_buffers_cts_tb.sv
// testbench for the uart receiver command, buffers and cts block
`include "uart_rx_cmd_buffers_cts_consts.vh"
`default_nettype none
module uart_rx_cmd_buffers_cts_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer   BIT  = 8;   // short bit time
  localparam integer   CTS  = 20;  // short cts filter
  localparam bit [3:0] CMD  = `OFS_CHANNEL_COMMAND;
  localparam bit [3:0] RB   = `OFS_RECEIVE_BUFFER;
  localparam bit [3:0] TB   = `OFS_TRANSMIT_BUFFER;
  localparam bit [3:0] IPC  = `OFS_INPUT_PORT_CHANGE;
  localparam bit [3:0] CFG  = `OFS_CHANNEL_CONFIG;
  localparam bit [3:0] STAT = `OFS_CHANNEL_STATUS;
  logic       clk;
  logic       srst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  wire  [7:0] rdata;
  wire        rxd;
  wire        cts_n;
  wire        txd;
  wire        irq;
  int         n_errors = 0;
  int         compares = 0;
  logic [7:0] v;
  // rows: write flag, address, write data or expected read data
  logic [12:0] rows [9] = '{13'h1707, 13'h1418, 13'h0418, 13'h0000,
    13'h0200, 13'h0800, 13'h0100, 13'h0502, 13'h0600};
  uart_rx_cmd_buffers_cts #(.BIT_CYC(BIT), .CTS_CYC(CTS)) u_dut (
    .sys_clk_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .receive_data_pin_i(rxd),
    .clear_to_send_input_n_i(cts_n), .transmit_data_pin_o(txd),
    .irq_o(irq));
  serial_peer #(.BIT_CYC(BIT)) u_peer (
    .clk_i(clk), .tx_pin_i(txd), .rx_pin_o(rxd), .cts_n_o(cts_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cmp8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk(input string what, input logic [3:0] a,
                     input logic [7:0] e);
    rd_reg(a, v);
    cmp8(what, e, v);
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    srst  <= 1'b1;
    addr  <= 4'h0;
    wdata <= 8'h00;
    wr    <= 1'b0;
    rd    <= 1'b0;
    idle(16);
    srst <= 1'b0;
    // cts loads on the second edge, the change flag one edge later
    idle(2);
    chk("ipc after reset", IPC, 8'h10);
    chk("ipc read again", IPC, 8'h00);
    foreach (rows[i]) begin
      if (rows[i][12]) wr_reg(rows[i][11:8], rows[i][7:0]);
      else chk("register row", rows[i][11:8], rows[i][7:0]);
    end
    // short glitch must not pass the filter
    u_peer.set_cts(1'b1);
    idle(5);
    u_peer.set_cts(1'b0);
    idle(3 * CTS);
    chk("ipc glitch", IPC, 8'h00);
    u_peer.set_cts(1'b1);
    idle(2 * CTS);
    cmp8("irq on change", 8'h01, {7'h0, irq});
    chk("ipc change", IPC, 8'h11);
    idle(2);
    cmp8("irq after read", 8'h00, {7'h0, irq});
    wr_reg(CFG, 8'h08);
    u_peer.set_cts(1'b0);
    idle(2 * CTS);
    cmp8("irq change disabled", 8'h00, {7'h0, irq});
    chk("ipc change no irq", IPC, 8'h10);
    // three deep queue, fourth character lost
    wr_reg(CMD, 8'h01);
    for (int i = 0; i < 4; i++) u_peer.send_char(8'ha1 + 8'(i));
    idle(BIT);
    chk("status queue full", STAT, 8'h73);
    chk("int status rx", `OFS_INT_STATUS, 8'h06);
    for (int i = 0; i < 3; i++) chk("rx queue", RB, 8'ha1 + 8'(i));
    chk("rx queue empty", RB, 8'h00);
    // disable in mid character drops it
    fork
      u_peer.send_char(8'h5a);
      begin
        idle(4 * BIT);
        wr_reg(CMD, 8'h02);
      end
    join
    idle(BIT);
    chk("rx partial dropped", RB, 8'h00);
    wr_reg(CMD, 8'h03);
    wr_reg(CMD, 8'h00);
    u_peer.send_char(8'h66);
    idle(BIT);
    chk("rx stays disabled", RB, 8'h00);
    wr_reg(CFG, 8'h03);
    wr_reg(CMD, 8'h01);
    rd_reg(STAT, v);
    cmp8("enable in multidrop", 8'h00, v & 8'h01);
    u_peer.send_char(8'h5a);
    idle(BIT);
    chk("multidrop rx", RB, 8'h5a);
    // loop-back; third write lands while ready is low
    wr_reg(CFG, 8'h0c);
    idle(2);
    wr_reg(TB, 8'h3c);
    idle(4);
    wr_reg(TB, 8'hc3);
    wr_reg(TB, 8'h99);
    idle(30 * BIT);
    chk("loop rx first", RB, 8'h3c);
    chk("loop rx second", RB, 8'hc3);
    chk("loop rx refused", RB, 8'h00);
    cmp8("line count", 8'h02, 8'(u_peer.got.size()));
    cmp8("line first", 8'h3c, u_peer.got[0]);
    cmp8("line second", 8'hc3, u_peer.got[1]);
    wr_reg(`OFS_INT_MASK, 8'h00);
    idle(2);
    cmp8("irq masked", 8'h00, {7'h0, irq});
    wr_reg(`OFS_INT_STATUS, 8'h07);
    chk("int status cleared", `OFS_INT_STATUS, 8'h00);
    print_verdict;
  end
  // hang guard, far beyond the one thousand or so cycles needed
  initial begin
    idle(20000);
    n_errors++;
    print_verdict;
  end
endmodule
bind uart_rx_cmd_buffers_cts uart_rx_cmd_buffers_cts_sva #(
  .CTS_CYC(CTS_CYC)) u_sva (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .receive_data_pin_i(receive_data_pin_i),
  .clear_to_send_input_n_i(clear_to_send_input_n_i),
  .transmit_data_pin_o(transmit_data_pin_o), .irq_o(irq_o));
`default_nettype wire
